// ===== core/sfm_map.svh
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH
`define SFM_OFF_FILL 12'h334
`define SFM_OFF_TMO 12'h338
`define SFM_OFF_PTR 12'h33c
`define SFM_OFF_ISTAT 12'h340
`define SFM_OFF_IEN 12'h344
`define SFM_OFF_ICLR 12'h348
`define SFM_OFF_RDAT 12'h34c
`define SFM_FILL_ASYNC 0
`define SFM_FILL_PER 1
`define SFM_FILL_ISO 2
`define SFM_FILL_W 3
`define SFM_PTR_ADDR_W 16
`define SFM_PTR_BANK_LSB 16
`define SFM_PTR_BANK_MSB 17
`define SFM_RST_FILL 32'h0000_0000
`define SFM_RST_TMO 32'h0000_0000
`define SFM_RST_PTR 32'h0000_0000
`define SFM_CLK_MHZ 250
`define SFM_MS_NS 1000000
`define SFM_PERIOD_NS 4
`define SFM_CYC_PER_MS (`SFM_MS_NS / `SFM_PERIOD_NS)
`define SFM_IRQ_TMO 0
`define SFM_IRQ_W 1
`endif

// ===== core/sfm_pkg.sv
package sfm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ASYNC,
    ST_PER,
    ST_ISO
  } sfm_walk_t;
  typedef logic [1:0] sfm_bank_t;
endpackage

// ===== core/sfm_ptr_if.sv
`timescale 1ns/1ps
interface sfm_ptr_if;
  logic load;
  logic [1:0] load_bank;
  logic [15:0] load_addr;
  logic step;
  logic [1:0] step_bank;
  logic [15:0] cur_addr;
  modport ctl (output load, load_bank, load_addr, step, step_bank,
    input cur_addr);
  modport ptr (input load, load_bank, load_addr, step, step_bank,
    output cur_addr);
endinterface

// ===== core/sfm_bank_ptrs.sv
`timescale 1ns/1ps
module sfm_bank_ptrs #(
  parameter int BANKS = 4,
  parameter int AW = 16
) (
  // clocking
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  // pointer control
  sfm_ptr_if.ptr p
);
  logic [AW-1:0] ptr_r [BANKS];
  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      // each bank has its own pointer, untouched by others
      always_ff @(posedge clock) begin
        if (!resetn) begin
          ptr_r[g] <= '0;
        end else if (ce) begin
          if (p.load && p.load_bank == 2'(g)) begin
            ptr_r[g] <= p.load_addr;
          end else if (p.step && p.step_bank == 2'(g)) begin
            ptr_r[g] <= ptr_r[g] + AW'(1);
          end
        end
      end
    end
  endgenerate
  assign p.cur_addr = ptr_r[p.step_bank];
endmodule

// ===== core/sfm_regs.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sfm_map.svh"
// Operation
// - setting a list flag starts a walk over that list's valid headers
// - bit 2 enables isochronous list processing, else it is skipped
// - bit 1 enables periodic list processing, else it is skipped
// - bit 0 enables asynchronous list processing, else it is skipped
// - 32-bit ms timeout raises interrupt for completed async descriptors
// - bits 17:16 pick one of four banks for programmed-io access
// - bits 15:0 give start address of incrementing programmed-io reads
// - write latches bank pointer; each read of bank increments it
module sfm_regs #(
  parameter int CYC_PER_MS = `SFM_CYC_PER_MS
) (
  // clocking
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // scheduler side
  input wire logic walk_done,
  input wire logic hdr_valid,
  input wire logic hdr_skip,
  input wire logic async_done,
  output logic walk_active_r,
  output logic [1:0] walk_list_r,
  output logic hdr_take_r,
  // programmed-io memory port
  output logic [1:0] mem_bank_r,
  output logic [15:0] mem_addr_r,
  output logic mem_rd_r,
  input wire logic [31:0] mem_rdata,
  // interrupt
  output logic irq_r
);
  sfm_ptr_if pif ();
  // one pointer per bank, so a reload leaves the others alone
  sfm_bank_ptrs #(.BANKS(4), .AW(`SFM_PTR_ADDR_W)) u_ptrs (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .p(pif)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a[11:2] == o[11:2];
  endfunction

  logic [`SFM_FILL_W-1:0] fill_r;
  logic [31:0] tmo_r;
  logic [31:0] ptr_reg_r;
  logic [`SFM_IRQ_W-1:0] istat_r, ien_r;
  logic [11:0] aw_r, ar_r;
  logic aw_have_r, w_have_r;
  logic [31:0] w_r;
  logic [3:0] ws_r;
  logic rd_pend_r;
  sfm_pkg::sfm_walk_t walk_r, walk_nxt;
  logic [31:0] ms_cnt_r, ms_tot_r;
  logic tmo_arm_r;
  // reserved list-flag bits are not stored and read as zero
  wire [31:0] fill_rst = `SFM_RST_FILL;

  // write channel capture, any order
  // the write lands one cycle after both halves are held
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [31:0] wmask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}},
    {8{ws_r[0]}}};
  wire wr_fill = wr_go && hit(aw_r, `SFM_OFF_FILL);
  wire wr_tmo = wr_go && hit(aw_r, `SFM_OFF_TMO);
  wire wr_ptr = wr_go && hit(aw_r, `SFM_OFF_PTR);
  wire wr_ien = wr_go && hit(aw_r, `SFM_OFF_IEN);
  wire wr_iclr = wr_go && hit(aw_r, `SFM_OFF_ICLR);
  wire wr_ok = wr_fill || wr_tmo || wr_ptr || wr_ien || wr_iclr;
  wire [31:0] ptr_new = (ptr_reg_r & ~wmask) | (w_r & wmask);
  wire [31:0] fill_new = ({29'h0, fill_r} & ~wmask) | (w_r & wmask);

  // read path
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_mem = hit(ar_r, `SFM_OFF_RDAT);
  wire [31:0] rd_val =
    hit(ar_r, `SFM_OFF_FILL) ? {29'h0, fill_r} :
    hit(ar_r, `SFM_OFF_TMO) ? tmo_r :
    hit(ar_r, `SFM_OFF_PTR) ? {14'h0, ptr_reg_r[17:0]} :
    hit(ar_r, `SFM_OFF_ISTAT) ? {31'h0, istat_r} :
    hit(ar_r, `SFM_OFF_IEN) ? {31'h0, ien_r} :
    rd_mem ? mem_rdata : 32'h0000_0000;
  wire rd_ok = hit(ar_r, `SFM_OFF_FILL) || hit(ar_r, `SFM_OFF_TMO) ||
    hit(ar_r, `SFM_OFF_PTR) || hit(ar_r, `SFM_OFF_ISTAT) ||
    hit(ar_r, `SFM_OFF_IEN) || rd_mem;
  wire [1:0] sel_bank = ptr_reg_r[`SFM_PTR_BANK_MSB:`SFM_PTR_BANK_LSB];

  // pointer control: latch on write, step after each memory data read
  assign pif.load = wr_ptr;
  assign pif.load_bank = ptr_new[`SFM_PTR_BANK_MSB:`SFM_PTR_BANK_LSB];
  assign pif.load_addr = ptr_new[15:0];
  // step only once the data word has been accepted
  assign pif.step = rd_pend_r && rd_mem && s_axi_rvalid && s_axi_rready;
  assign pif.step_bank = sel_bank;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_r <= 12'h000;
      w_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      // ce low holds the handshake state as well
      s_axi_awready <= !aw_have_r && !aw_take;
      s_axi_wready <= !w_have_r && !w_take;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      rd_pend_r <= 1'b0;
      ar_r <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= !rd_pend_r && !ar_take && !s_axi_rvalid;
      if (ar_take) begin
        ar_r <= s_axi_araddr;
        rd_pend_r <= 1'b1;
      end
      // one cycle for the memory address to settle
      if (rd_pend_r && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        rd_pend_r <= 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fill_r <= fill_rst[`SFM_FILL_W-1:0];
      tmo_r <= `SFM_RST_TMO;
      ptr_reg_r <= `SFM_RST_PTR;
      ien_r <= '0;
      mem_bank_r <= 2'h0;
      mem_addr_r <= 16'h0000;
      mem_rd_r <= 1'b0;
    end else if (ce) begin
      if (wr_fill) begin
        fill_r <= fill_new[`SFM_FILL_W-1:0];
      end
      if (wr_tmo) begin
        tmo_r <= (tmo_r & ~wmask) | (w_r & wmask);
      end
      // reserved pointer bits are not kept
      if (wr_ptr) begin
        ptr_reg_r <= {14'h0, ptr_new[17:0]};
      end
      if (wr_ien) begin
        ien_r <= w_r[`SFM_IRQ_W-1:0];
      end
      mem_bank_r <= sel_bank;
      mem_addr_r <= pif.cur_addr;
      mem_rd_r <= pif.step;
    end
  end

  // list walker: async, periodic, iso in turn, each only when filled
  always_comb begin
    walk_nxt = walk_r;
    case (walk_r)
      sfm_pkg::ST_IDLE: begin
        if (fill_r[`SFM_FILL_ASYNC]) begin
          walk_nxt = sfm_pkg::ST_ASYNC;
        end else if (fill_r[`SFM_FILL_PER]) begin
          walk_nxt = sfm_pkg::ST_PER;
        end else if (fill_r[`SFM_FILL_ISO]) begin
          walk_nxt = sfm_pkg::ST_ISO;
        end
      end
      // fixed order: async, then periodic, then iso
      sfm_pkg::ST_ASYNC: begin
        if (walk_done) begin
          walk_nxt = fill_r[`SFM_FILL_PER] ? sfm_pkg::ST_PER :
            fill_r[`SFM_FILL_ISO] ? sfm_pkg::ST_ISO : sfm_pkg::ST_IDLE;
        end
      end
      sfm_pkg::ST_PER: begin
        if (walk_done) begin
          walk_nxt = fill_r[`SFM_FILL_ISO] ? sfm_pkg::ST_ISO :
            sfm_pkg::ST_IDLE;
        end
      end
      sfm_pkg::ST_ISO: begin
        if (walk_done) begin
          walk_nxt = sfm_pkg::ST_IDLE;
        end
      end
      default: walk_nxt = sfm_pkg::ST_IDLE;
    endcase
  end

  wire walking = walk_r != sfm_pkg::ST_IDLE;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      walk_r <= sfm_pkg::ST_IDLE;
      walk_active_r <= 1'b0;
      walk_list_r <= 2'h0;
      hdr_take_r <= 1'b0;
    end else if (ce) begin
      walk_r <= walk_nxt;
      walk_active_r <= walk_nxt != sfm_pkg::ST_IDLE;
      walk_list_r <= walk_nxt == sfm_pkg::ST_ISO ? 2'h2 :
        walk_nxt == sfm_pkg::ST_PER ? 2'h1 : 2'h0;
      hdr_take_r <= walking && hdr_valid && !hdr_skip;
    end
  end

  // async done timeout in milliseconds
  wire ms_tick = ms_cnt_r == CYC_PER_MS - 1;
  // a zero timeout still waits one millisecond
  wire tmo_fire = tmo_arm_r && ms_tick &&
    (ms_tot_r + 32'h0000_0001 >= tmo_r);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ms_cnt_r <= 32'h0000_0000;
      ms_tot_r <= 32'h0000_0000;
      tmo_arm_r <= 1'b0;
      istat_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      // the millisecond count restarts with every new arming
      if (async_done && !tmo_arm_r) begin
        tmo_arm_r <= 1'b1;
        ms_cnt_r <= 32'h0000_0000;
        ms_tot_r <= 32'h0000_0000;
      end else if (tmo_arm_r) begin
        ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
        if (ms_tick) begin
          ms_tot_r <= ms_tot_r + 32'h0000_0001;
        end
        if (tmo_fire) begin
          tmo_arm_r <= 1'b0;
        end
      end
      // set wins over a same-cycle clear
      istat_r <= (istat_r & ~(wr_iclr ? w_r[`SFM_IRQ_W-1:0] : '0)) |
        {tmo_fire};
      irq_r <= |((istat_r | {tmo_fire}) & ien_r &
        ~(wr_iclr ? w_r[`SFM_IRQ_W-1:0] & ~{tmo_fire} : '0));
    end
  end
endmodule

// ===== testbench/sfm_regs_sva.sv
`timescale 1ns/1ps
module sfm_regs_sva (
  // clocking
  input wire logic clock,
  input wire logic resetn,
  // bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // scheduler
  input wire logic hdr_valid,
  input wire logic hdr_skip,
  input wire logic async_done,
  input wire logic walk_active_r,
  input wire logic [1:0] walk_list_r,
  input wire logic hdr_take_r,
  // memory and interrupt
  input wire logic [1:0] mem_bank_r,
  input wire logic mem_rd_r,
  input wire logic irq_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_hdr_ok;
    walk_active_r && hdr_valid && !hdr_skip;
  endsequence
  a_hdr_take: assert property (s_hdr_ok |=> hdr_take_r)
    else $error("header not taken");
  a_hdr_only: assert property (
    hdr_take_r |-> $past(walk_active_r && hdr_valid && !hdr_skip))
    else $error("header taken without cause");
  a_list_code: assert property (walk_active_r |-> walk_list_r != 2'h3)
    else $error("bad list code");
  a_rd_answer: assert property (s_ar_taken |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  a_step_cause: assert property (
    mem_rd_r |-> $past(s_axi_rvalid && s_axi_rready) ||
    $past(s_axi_rvalid && s_axi_rready, 2))
    else $error("pointer step without read");
  a_bank_wr: assert property (
    $changed(mem_bank_r) |-> $past(s_axi_bvalid))
    else $error("bank changed without write");
  a_irq_delay: assert property ($rose(irq_r) |-> !$past(async_done))
    else $error("interrupt too early");
endmodule
bind sfm_regs sfm_regs_sva u_sfm_regs_sva (.*);

// ===== testbench/tb_sched_fill_and_memread_regs.sv
`timescale 1ns/1ps
`include "sfm_map.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_sched_fill_and_memread_regs;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, walk_active_r, hdr_take_r, mem_rd_r, irq_r;
  logic [1:0] s_axi_bresp, s_axi_rresp, walk_list_r, mem_bank_r, rs;
  logic walk_done = 1'b0, hdr_valid = 1'b0, hdr_skip = 1'b0;
  logic async_done = 1'b0;
  logic ce = 1'b1;
  logic [15:0] mem_addr_r;
  int miscompares = 0;
  int compares = 0;
  int n;
  always #2 clock = ~clock;
  // memory returns its own bank and address
  assign mem_rdata = {14'h0, mem_bank_r, mem_addr_r};
  sfm_regs #(.CYC_PER_MS(10)) u_sfm_regs (.*);
  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task pulse_done;
    walk_done <= 1'b1;
    @(posedge clock);
    walk_done <= 1'b0;
  endtask
  task t_regs;
    rd(`SFM_OFF_FILL);
    `CHK("fill reset", 32'h0, rv)
    rd(`SFM_OFF_PTR);
    `CHK("ptr reset", 32'h0, rv)
    wr(`SFM_OFF_TMO, 32'hdead_beef);
    `CHK("write resp", 2'h0, rs)
    rd(`SFM_OFF_TMO);
    `CHK("timeout", 32'hdead_beef, rv)
    wr(`SFM_OFF_PTR, 32'h0003_1234);
    rd(`SFM_OFF_PTR);
    `CHK("ptr", 32'h0003_1234, rv)
    rd(12'h100);
    `CHK("unmapped resp", 2'h2, rs)
    wr(`SFM_OFF_ISTAT, 32'h1);
    `CHK("status write resp", 2'h2, rs)
    `CHK("no walk", 1'b0, walk_active_r)
  endtask
  task t_walk;
    hdr_valid <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`SFM_OFF_FILL, (i == 3) ? 32'h7 : 32'h1 << i);
      n = 0;
      while (!walk_active_r && n < 50) begin
        @(posedge clock);
        n++;
      end
      @(posedge clock);
      `CHK("list", (i == 3) ? 2'h0 : 2'(i), walk_list_r)
      `CHK("take", 1'b1, hdr_take_r)
      hdr_skip <= (i == 3);
      repeat (2) @(posedge clock);
      `CHK("take skip", i != 3, hdr_take_r)
      wr(`SFM_OFF_FILL, 32'h0);
      pulse_done;
      repeat (3) @(posedge clock);
      `CHK("idle", 1'b0, walk_active_r)
    end
    hdr_skip <= 1'b0;
    hdr_valid <= 1'b0;
  endtask
  task t_order;
    wr(`SFM_OFF_FILL, 32'h5);
    repeat (2) @(posedge clock);
    `CHK("first walk", 1'b1, walk_active_r)
    `CHK("first list", 2'h0, walk_list_r)
    pulse_done;
    repeat (2) @(posedge clock);
    `CHK("per skipped", 2'h2, walk_list_r)
    wr(`SFM_OFF_FILL, 32'h0);
    pulse_done;
    repeat (2) @(posedge clock);
    `CHK("all idle", 1'b0, walk_active_r)
  endtask
  task t_ce;
    wr(`SFM_OFF_FILL, 32'h1);
    ce <= 1'b0;
    pulse_done;
    repeat (3) @(posedge clock);
    `CHK("frozen walk", 1'b1, walk_active_r)
    ce <= 1'b1;
    wr(`SFM_OFF_FILL, 32'h0);
    pulse_done;
    repeat (2) @(posedge clock);
    `CHK("thawed idle", 1'b0, walk_active_r)
  endtask
  task t_ptr;
    wr(`SFM_OFF_PTR, 32'h0001_00fe);
    for (int i = 0; i < 3; i++) begin
      rd(`SFM_OFF_RDAT);
      `CHK("bank1 data", 32'h0001_00fe + i, rv)
      @(posedge clock);
      `CHK("step pulse", 1'b1, mem_rd_r)
    end
    wr(`SFM_OFF_PTR, 32'h0002_0040);
    @(posedge clock);
    `CHK("bank", 2'h2, mem_bank_r)
    rd(`SFM_OFF_RDAT);
    `CHK("bank2 data", 32'h0002_0040, rv)
  endtask
  task t_irq;
    wr(`SFM_OFF_TMO, 32'h2);
    wr(`SFM_OFF_IEN, 32'h1);
    async_done <= 1'b1;
    @(posedge clock);
    async_done <= 1'b0;
    n = 0;
    while (!irq_r && n < 100) begin
      @(posedge clock);
      n++;
    end
    `CHK("irq delay", 1'b1, n >= 18 && n <= 24)
    rd(`SFM_OFF_ISTAT);
    `CHK("status", 32'h1, rv)
    wr(`SFM_OFF_ICLR, 32'h1);
    wr(`SFM_OFF_IEN, 32'h0);
    async_done <= 1'b1;
    @(posedge clock);
    async_done <= 1'b0;
    repeat (40) @(posedge clock);
    `CHK("irq masked", 1'b0, irq_r)
    wr(`SFM_OFF_IEN, 32'h1);
    repeat (2) @(posedge clock);
    `CHK("irq enabled", 1'b1, irq_r)
    wr(`SFM_OFF_ICLR, 32'h1);
    repeat (2) @(posedge clock);
    `CHK("irq cleared", 1'b0, irq_r)
  endtask
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_regs;
    t_walk;
    t_order;
    t_ce;
    t_ptr;
    t_irq;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_sim;
  end
endmodule
